// >>> core/fdc_dco_ctrl.sv
// fractional divider dco control: step, mask, direct writes, zero-delay reset delay
// assumes a byte-wide register port in the core clock domain and async step pins
`timescale 1ns/10ps
module fdc_dco_ctrl #(
  parameter int NDIV            = 5,
  parameter int HARD_RST_CYCLES = fdc_pkg::HARD_RST_CYCLES
) (
  input  wire logic             i_core_clk,
  input  wire logic             i_reset_n,
  input  wire logic             i_reg_wr,                  // register write strobe
  input  wire logic [15:0]      i_reg_addr,                // register byte address
  input  wire logic [7:0]       i_reg_wdata,               // write byte
  output logic      [7:0]       o_reg_rdata,               // read byte, one cycle later
  input  wire logic             i_freq_increment_request,  // async pin, active high
  input  wire logic             i_freq_decrement_request,  // async pin, active high
  input  wire logic             i_hard_reset_pin_n,        // async pin, active low
  output logic                  o_zero_delay_mode,         // loop mode is zero-delay
  output logic                  o_external_feedback_sel,   // feedback from external input
  output logic                  o_hard_reset,              // one-cycle hard reset pulse
  output logic                  o_hard_reset_pending,      // delay running
  output logic [NDIV*44-1:0]    o_divider_numerator,       // live numerators
  output logic [NDIV*32-1:0]    o_divider_denominator,     // live denominators
  output logic [NDIV-1:0]       o_integer_bypass_field     // integer bypass per divider
);
  localparam int CW = $clog2(HARD_RST_CYCLES + 1);

  // byte of a wide word, by index
  function automatic logic [7:0] byte_of(input logic [63:0] w, input logic [2:0] i);
    byte_of = w[i*8 +: 8];
  endfunction

  // clamp a numerator to the legal ratio window for its denominator
  // up tells which end a wrapped sum ran past; bit 44 cannot tell that apart
  function automatic logic [43:0] clamp_num(input logic [44:0] n, input logic [31:0] d,
                                            input logic up);
    logic [43:0] lo;
    logic [43:0] hi;
    lo = 44'(d) * 44'(fdc_pkg::RATIO_MIN);
    hi = 44'(d) * 44'(fdc_pkg::RATIO_MAX);
    if (n[44]) clamp_num = (up ? hi : lo);       // wrapped: over- or underflow
    else if (n[43:0] < lo) clamp_num = lo;
    else if (n[43:0] > hi) clamp_num = hi;
    else clamp_num = n[43:0];
  endfunction

  // pin synchronisers, two flops each
  logic [2:0] pin_s1_q;
  logic [2:0] pin_s2_q;
  logic [2:0] pin_s3_q;                          // previous synced value for edges

  // register state
  logic [2:0]            loop_mode_q;            // loop mode selection field
  logic [43:0]           step_word;              // frequency step word, both halves
  logic [11:0]           step_hi_q;              // step word bits 43:32
  logic [43:0]           step_num [NDIV];        // stepped numerators, clamped
  logic [NDIV-1:0]       step_mask_q;            // step divider mask
  logic [NDIV-1:0]       bypass_q;               // integer bypass field
  logic [43:0]           pend_num_q [NDIV];      // written, not yet committed
  logic [31:0]           pend_den_q [NDIV];
  logic [NDIV-1:0]       pend_dirty_q;           // pending differs from live
  logic [43:0]           num_q [NDIV];           // live numerators
  logic [31:0]           den_q [NDIV];           // live denominators
  logic                  reg_inc_q;              // register step requests, one cycle
  logic                  reg_dec_q;
  logic                  reg_rst_q;
  logic [CW-1:0]         rst_cnt_q;
  logic                  rst_pend_q;
  logic                  hard_rst_q;
  logic [7:0]            rdata_q;

  // decoded events
  logic pin_inc;
  logic pin_dec;
  logic pin_rst;
  logic do_inc;
  logic do_dec;
  logic rst_req;
  logic [NDIV-1:0] upd_sel;
  logic wr_ctrl;
  logic wr_upd;

  // two-flop sync, then edge detect on the second stage only
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pin_s1_q <= 3'h4;
      pin_s2_q <= 3'h4;
      pin_s3_q <= 3'h4;
    end else begin
      pin_s1_q <= {i_hard_reset_pin_n, i_freq_decrement_request, i_freq_increment_request};
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end

  assign pin_inc = pin_s2_q[0] & ~pin_s3_q[0];
  assign pin_dec = pin_s2_q[1] & ~pin_s3_q[1];
  assign pin_rst = ~pin_s2_q[2] & pin_s3_q[2];
  assign wr_ctrl = i_reg_wr && (i_reg_addr == fdc_pkg::STEP_CTRL_OFS);
  assign wr_upd  = i_reg_wr && (i_reg_addr == fdc_pkg::UPDATE_OFS);

  // either source, same effect; both together cancel
  assign do_inc  = (pin_inc | reg_inc_q) & ~(pin_dec | reg_dec_q);
  assign do_dec  = (pin_dec | reg_dec_q) & ~(pin_inc | reg_inc_q);
  assign rst_req = pin_rst | reg_rst_q;

  // update strobes: per divider bit, or the global bit for all dirty dividers
  always_comb begin
    upd_sel = '0;
    if (wr_upd) begin
      upd_sel = i_reg_wdata[NDIV-1:0];
      if (i_reg_wdata[fdc_pkg::UPD_ALL_BIT]) upd_sel = pend_dirty_q;
    end
  end

  // configuration registers and register-side step strobes
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      loop_mode_q <= fdc_pkg::LOOP_MODE_RST;
      step_hi_q   <= '0;
      step_mask_q <= '0;
      bypass_q    <= fdc_pkg::BYPASS_RST;
      reg_inc_q   <= 1'b0;
      reg_dec_q   <= 1'b0;
      reg_rst_q   <= 1'b0;
    end else if (hard_rst_q) begin
      // hard reset restores the stored power-up settings
      loop_mode_q <= fdc_pkg::LOOP_MODE_RST;
      step_hi_q   <= '0;
      step_mask_q <= '0;
      bypass_q    <= fdc_pkg::BYPASS_RST;
      reg_inc_q   <= 1'b0;
      reg_dec_q   <= 1'b0;
      reg_rst_q   <= 1'b0;
    end else begin
      reg_inc_q <= wr_ctrl & i_reg_wdata[fdc_pkg::CTRL_INC_BIT];
      reg_dec_q <= wr_ctrl & i_reg_wdata[fdc_pkg::CTRL_DEC_BIT];
      reg_rst_q <= wr_ctrl & i_reg_wdata[fdc_pkg::CTRL_RST_BIT];
      if (i_reg_wr) begin
        case (i_reg_addr)
          fdc_pkg::LOOP_MODE_OFS:    loop_mode_q <= i_reg_wdata[2:0];
          fdc_pkg::STEP_MASK_OFS:    step_mask_q <= i_reg_wdata[NDIV-1:0];
          fdc_pkg::BYPASS_OFS:       bypass_q    <= i_reg_wdata[NDIV-1:0];
          fdc_pkg::STEP_WORD_HI_OFS: step_hi_q <= {step_hi_q[3:0], i_reg_wdata};
          default: begin
          end
        endcase
      end
    end
  end

  // zero-delay hard reset delay; normal mode resets at once
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rst_cnt_q  <= '0;
      rst_pend_q <= 1'b0;
      hard_rst_q <= 1'b0;
    end else begin
      hard_rst_q <= 1'b0;
      if (rst_pend_q) begin
        if (rst_cnt_q == CW'(HARD_RST_CYCLES - 1)) begin
          rst_pend_q <= 1'b0;
          hard_rst_q <= 1'b1;
        end else begin
          rst_cnt_q <= rst_cnt_q + 1'b1;
        end
      end else if (rst_req) begin
        if (loop_mode_q == fdc_pkg::MODE_ZERO_DELAY) begin
          rst_pend_q <= 1'b1;
          rst_cnt_q  <= '0;
        end else begin
          hard_rst_q <= 1'b1;
        end
      end
    end
  end

  // stepped numerator per divider, clamped to the legal ratio window
  always_comb begin
    for (int k = 0; k < NDIV; k++) begin
      if (do_inc) begin
        step_num[k] = clamp_num({1'b0, num_q[k]} + {1'b0, step_word}, den_q[k], 1'b1);
      end else begin
        step_num[k] = clamp_num({1'b0, num_q[k]} - {1'b0, step_word}, den_q[k], 1'b0);
      end
    end
  end

  // divider numerators and denominators
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pend_dirty_q <= '0;
      for (int k = 0; k < NDIV; k++) begin
        num_q[k]      <= fdc_pkg::NUM_RST;
        den_q[k]      <= fdc_pkg::DEN_RST;
        pend_num_q[k] <= fdc_pkg::NUM_RST;
        pend_den_q[k] <= fdc_pkg::DEN_RST;
      end
    end else if (hard_rst_q) begin
      pend_dirty_q <= '0;
      for (int k = 0; k < NDIV; k++) begin
        num_q[k]      <= fdc_pkg::NUM_RST;
        den_q[k]      <= fdc_pkg::DEN_RST;
        pend_num_q[k] <= fdc_pkg::NUM_RST;
        pend_den_q[k] <= fdc_pkg::DEN_RST;
      end
    end else begin
      for (int k = 0; k < NDIV; k++) begin
        // direct writes land in pending copies
        if (i_reg_wr) begin
          for (int b = 0; b < 4; b++) begin
            if (i_reg_addr == 16'(fdc_pkg::DIV_BASE_OFS + k*fdc_pkg::DIV_STRIDE) &&
                b == 0) begin
              pend_num_q[k][7:0] <= i_reg_wdata;
              pend_dirty_q[k]    <= 1'b1;
            end
          end
          if (i_reg_addr == 16'(fdc_pkg::DIV_BASE_OFS + k*fdc_pkg::DIV_STRIDE + 1)) begin
            pend_num_q[k] <= {pend_num_q[k][35:0], i_reg_wdata};    // shift-in bytes
            pend_dirty_q[k] <= 1'b1;
          end
          if (i_reg_addr == 16'(fdc_pkg::DIV_BASE_OFS + k*fdc_pkg::DIV_STRIDE + 2)) begin
            pend_den_q[k] <= {pend_den_q[k][23:0], i_reg_wdata};
            pend_dirty_q[k] <= 1'b1;
          end
        end
        if (upd_sel[k]) begin
          // commit; ratio held in the legal window
          num_q[k] <= clamp_num({1'b0, pend_num_q[k]}, pend_den_q[k], 1'b0);
          den_q[k]        <= pend_den_q[k];
          pend_dirty_q[k] <= 1'b0;
        end else if (!step_mask_q[k] && (do_inc || do_dec)) begin
          num_q[k]      <= step_num[k];
          pend_num_q[k] <= step_num[k];                              // pending follows live
        end
      end
    end
  end

  // low 32 bits of the step word, byte shifted in at the low offset
  logic [31:0] step_lo_q;
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      step_lo_q <= '0;
    end else if (hard_rst_q) begin
      step_lo_q <= '0;
    end else if (i_reg_wr && i_reg_addr == fdc_pkg::STEP_WORD_OFS) begin
      step_lo_q <= {step_lo_q[23:0], i_reg_wdata};
    end
  end

  // read mux, registered
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rdata_q <= '0;
    end else begin
      case (i_reg_addr)
        fdc_pkg::LOOP_MODE_OFS: rdata_q <= {5'h00, loop_mode_q};
        fdc_pkg::STEP_MASK_OFS: rdata_q <= 8'(step_mask_q);
        fdc_pkg::BYPASS_OFS:    rdata_q <= 8'(bypass_q);
        fdc_pkg::STEP_CTRL_OFS: rdata_q <= {5'h00, rst_pend_q, 2'h0};
        fdc_pkg::UPDATE_OFS:    rdata_q <= 8'(pend_dirty_q);
        default: begin
          rdata_q <= 8'h00;
          for (int k = 0; k < NDIV; k++)
            if (i_reg_addr == 16'(fdc_pkg::DIV_BASE_OFS + k*fdc_pkg::DIV_STRIDE + 3))
              rdata_q <= byte_of({20'h00000, num_q[k]}, 3'h0);
        end
      endcase
    end
  end

  // outputs, all from flops
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_zero_delay_mode       <= 1'b0;
      o_external_feedback_sel <= 1'b0;
    end else begin
      o_zero_delay_mode       <= (loop_mode_q == fdc_pkg::MODE_ZERO_DELAY);
      o_external_feedback_sel <= (loop_mode_q == fdc_pkg::MODE_ZERO_DELAY);
    end
  end

  assign step_word = {step_hi_q, step_lo_q};
  assign o_reg_rdata          = rdata_q;
  assign o_hard_reset         = hard_rst_q;
  assign o_hard_reset_pending = rst_pend_q;
  assign o_integer_bypass_field = bypass_q;
  for (genvar g = 0; g < NDIV; g++) begin : g_out
    assign o_divider_numerator[g*44 +: 44]   = num_q[g];
    assign o_divider_denominator[g*32 +: 32] = den_q[g];
  end
endmodule

// >>> core/fdc_pkg.sv
// package for the fractional divider dco control block
// assumes a 125 MHz core clock and five output dividers
package fdc_pkg;
  // register offsets (byte addresses in the device map)
  localparam logic [15:0] LOOP_MODE_OFS     = 16'h091c;
  localparam logic [15:0] STEP_WORD_OFS     = 16'h0400; // 44-bit step word, low bits
  localparam logic [15:0] STEP_WORD_HI_OFS  = 16'h0401; // step word bits 43:32
  localparam logic [15:0] STEP_MASK_OFS     = 16'h0402; // step mask, bits 4:0
  localparam logic [15:0] STEP_CTRL_OFS     = 16'h0403; // bit0 inc, bit1 dec, bit2 hard reset
  localparam logic [15:0] BYPASS_OFS        = 16'h0404; // integer bypass, bits 4:0
  localparam logic [15:0] UPDATE_OFS        = 16'h0405; // bits 4:0 per divider, bit 5 all
  localparam logic [15:0] DIV_BASE_OFS      = 16'h0410; // per divider: +0 num lo, +1 num byte shift-in
  localparam logic [15:0] DIV_STRIDE        = 16'h0004; //   +2 den, +3 live num lo (read)
  // field positions
  localparam int CTRL_INC_BIT   = 0;
  localparam int CTRL_DEC_BIT   = 1;
  localparam int CTRL_RST_BIT   = 2;
  localparam int UPD_ALL_BIT    = 5;
  // loop mode encodings
  localparam logic [2:0] MODE_ZERO_DELAY = 3'h3;
  localparam logic [2:0] MODE_NORMAL     = 3'h4;
  // reset values
  localparam logic [2:0]  LOOP_MODE_RST = MODE_NORMAL;
  localparam logic [43:0] NUM_RST       = 44'h0000000001e; // ratio 30/1
  localparam logic [31:0] DEN_RST       = 32'h00000001;
  localparam logic [4:0]  BYPASS_RST    = 5'h1f;
  // timing
  localparam int  CLK_MHZ          = 125;
  localparam int  HARD_RST_DELAY_MS = 750;
  localparam int  HARD_RST_CYCLES   = HARD_RST_DELAY_MS * CLK_MHZ * 1000;
  // ratio limits
  localparam int  RATIO_MIN = 10;
  localparam int  RATIO_MAX = 4095;
endpackage

// >>> testbench/fdc_dco_ctrl_sva.sv
// port checker for the dco control block
// bound to fdc_dco_ctrl, watches only its ports on the core clock
`timescale 1ns/10ps
module fdc_dco_sva #(
  parameter int NDIV            = 5,
  parameter int HARD_RST_CYCLES = fdc_pkg::HARD_RST_CYCLES
) (
  input wire logic               i_core_clk,
  input wire logic               i_reset_n,
  input wire logic               i_reg_wr,
  input wire logic [15:0]        i_reg_addr,
  input wire logic [7:0]         i_reg_wdata,
  input wire logic [7:0]         o_reg_rdata,
  input wire logic               i_freq_increment_request,
  input wire logic               i_freq_decrement_request,
  input wire logic               i_hard_reset_pin_n,
  input wire logic               o_zero_delay_mode,
  input wire logic               o_external_feedback_sel,
  input wire logic               o_hard_reset,
  input wire logic               o_hard_reset_pending,
  input wire logic [NDIV*44-1:0] o_divider_numerator,
  input wire logic [NDIV*32-1:0] o_divider_denominator,
  input wire logic [NDIV-1:0]    o_integer_bypass_field
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_reset_n);
  int  pend_cnt_q; // length of the latest pending stretch
  wire mode_wr = i_reg_wr && i_reg_addr == fdc_pkg::LOOP_MODE_OFS; // loop mode write
  wire ctl_wr  = i_reg_wr && i_reg_addr == fdc_pkg::STEP_CTRL_OFS; // step control write
  wire pins_lo = !i_freq_increment_request && !i_freq_decrement_request; // step pins idle
  // restart on each new pending stretch, hold the value afterwards
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pend_cnt_q <= 0;
    end else if ($rose(o_hard_reset_pending)) begin
      pend_cnt_q <= 1;
    end else if (o_hard_reset_pending) begin
      pend_cnt_q <= pend_cnt_q + 1;
    end
  end
  feedback_follows_a: assert property (o_external_feedback_sel == o_zero_delay_mode)
    else $error("feedback select differs from loop mode");
  mode_zero_a: assert property (mode_wr && i_reg_wdata[2:0] == 3'h3
    |-> ##[1:2] o_zero_delay_mode) else $error("zero-delay mode not entered");
  mode_normal_a: assert property (mode_wr && i_reg_wdata[2:0] == 3'h4
    |-> ##[1:2] !o_zero_delay_mode) else $error("normal mode not entered");
  mode_readback_a: assert property (!i_reg_wr && !$past(i_reg_wr) &&
    i_reg_addr == fdc_pkg::LOOP_MODE_OFS && o_zero_delay_mode |=> o_reg_rdata[2:0] == 3'h3)
    else $error("loop mode reads back wrong");
  unmapped_read_a: assert property (i_reg_addr == 16'h0000 |=> o_reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  both_steps_a: assert property (ctl_wr && i_reg_wdata[1:0] == 2'h3 && pins_lo &&
    !i_reg_wdata[2] && !$past(ctl_wr) |=> $stable(o_divider_numerator)[*3])
    else $error("inc plus dec moved a numerator");
  den_held_a: assert property (i_reg_wr && i_reg_addr[15:4] == 12'h041 &&
    i_reg_addr[1:0] == 2'h2 |=> $stable(o_divider_denominator) || o_hard_reset)
    else $error("denominator live before update");
  zdm_delay_a: assert property ($rose(o_hard_reset) && o_zero_delay_mode |->
    pend_cnt_q >= HARD_RST_CYCLES - 4) else $error("zero-delay reset came early");
  pend_bound_a: assert property (pend_cnt_q <= HARD_RST_CYCLES + 4)
    else $error("reset pending too long");
  normal_reset_a: assert property ($fell(i_hard_reset_pin_n) && !o_zero_delay_mode &&
    !o_hard_reset_pending |-> ##[1:4] o_hard_reset) else $error("normal mode reset late");
endmodule
bind fdc_dco_ctrl fdc_dco_sva #(.NDIV(NDIV), .HARD_RST_CYCLES(HARD_RST_CYCLES)) u_sva (.*);

// >>> testbench/fdc_host_model.sv
// host model: register writes and reads, step pins and reset pin
// assumes the block samples its inputs on the rising core clock edge
`timescale 1ns/10ps
module fdc_host_model (
  input  wire logic        i_core_clk,
  input  wire logic [7:0]  i_reg_rdata,
  output logic             o_reg_wr,
  output logic [15:0]      o_reg_addr,
  output logic [7:0]       o_reg_wdata,
  output logic             o_inc_pin,
  output logic             o_dec_pin,
  output logic             o_rst_pin_n
);
  localparam int STEP_GAP = 125; // 1 us at the core clock rate
  // idle levels at time zero
  initial begin
    o_reg_wr    = 1'b0;
    o_reg_addr  = 16'h0000;
    o_reg_wdata = 8'h00;
    o_inc_pin   = 1'b0;
    o_dec_pin   = 1'b0;
    o_rst_pin_n = 1'b1;
  end
  // one write; the released bus shows inverted values
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge i_core_clk);
    o_reg_wr    <= 1'b1;
    o_reg_addr  <= a;
    o_reg_wdata <= d;
    @(posedge i_core_clk);
    o_reg_wr    <= 1'b0;
    o_reg_addr  <= ~a;
    o_reg_wdata <= ~d;
  endtask
  // 32-bit value shifted in, most significant byte first
  task automatic wr32(input logic [15:0] a, input logic [31:0] v);
    for (int i = 3; i >= 0; i--) begin
      wr(a, v[i*8 +: 8]);
    end
  endtask
  // read answered one cycle after the address is seen
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge i_core_clk);
    o_reg_addr <= a;
    repeat (2) @(posedge i_core_clk);
    d = i_reg_rdata;
  endtask
  // code bit0 increment, bit1 decrement, from pins or register
  task automatic step(input logic pin, input logic [1:0] code);
    if (pin) begin
      @(posedge i_core_clk);
      o_inc_pin <= code[0];
      o_dec_pin <= code[1];
      repeat (4) @(posedge i_core_clk);
      o_inc_pin <= 1'b0;
      o_dec_pin <= 1'b0;
    end else begin
      wr(fdc_pkg::STEP_CTRL_OFS, {6'h00, code});
    end
    repeat (STEP_GAP) @(posedge i_core_clk);
  endtask
  // short low pulse on the hard reset pin
  task automatic rst_pin;
    @(posedge i_core_clk);
    o_rst_pin_n <= 1'b0;
    repeat (4) @(posedge i_core_clk);
    o_rst_pin_n <= 1'b1;
  endtask
endmodule

// >>> testbench/test_fdc_dco_ctrl.sv
// self-checking bench for the dco control block
// assumes the host model owns every block input except clock and reset
`timescale 1ns/10ps
module test_fdc_dco_ctrl;
  localparam int HRC = 50; // shortened hard reset delay
  logic clk = 1'b0;
  logic rst_n;
  logic wr, inc, dec, rpin_n, zero_delay_mode, fbs, hrst, pend;
  logic [15:0] addr;
  logic [7:0] wdata, rdata;
  logic [219:0] num;
  logic [159:0] den;
  logic [4:0] byp;
  int fail_count = 0;
  int checks_done = 0;
  always #4 clk = ~clk;
  fdc_dco_ctrl #(.NDIV(5), .HARD_RST_CYCLES(HRC)) u_dut (.i_core_clk(clk), .i_reset_n(rst_n),
    .i_reg_wr(wr), .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
    .i_freq_increment_request(inc), .i_freq_decrement_request(dec),
    .i_hard_reset_pin_n(rpin_n), .o_zero_delay_mode(zero_delay_mode), .o_external_feedback_sel(fbs),
    .o_hard_reset(hrst), .o_hard_reset_pending(pend), .o_divider_numerator(num),
    .o_divider_denominator(den), .o_integer_bypass_field(byp));
  fdc_host_model u_host (.i_core_clk(clk), .i_reg_rdata(rdata), .o_reg_wr(wr),
    .o_reg_addr(addr), .o_reg_wdata(wdata), .o_inc_pin(inc), .o_dec_pin(dec),
    .o_rst_pin_n(rpin_n));
  // verdict and end of run
  task automatic conclude;
    if (fail_count == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // single compare for every value
  task automatic chk(input string n, input logic [43:0] e, input logic [43:0] g);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  // masked dividers 0 and 2 expect off, the rest on
  task automatic chk_num(input logic [43:0] on, input logic [43:0] off);
    for (int k = 0; k < 5; k++)
      chk("numerator", (k % 2 == 0 && k != 4) ? off : on, num[k*44 +: 44]);
  endtask
  // bounded wait for the reset pulse; a timeout ends the run
  task automatic wait_pulse(output int n);
    n = 0;
    while (hrst !== 1'b1 && n < 200) begin
      @(posedge clk);
      n++;
    end
    if (n >= 200) begin
      chk("reset pulse", 44'h1, 44'h0);
      conclude();
    end
  endtask
  // main sequence
  initial begin
    logic [7:0] d;
    int n;
    rst_n = 1'b0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk_num(44'd30, 44'd30);
    chk("denominator", 44'h1, {12'h000, den[0 +: 32]});
    u_host.rd(fdc_pkg::LOOP_MODE_OFS, d);
    chk("loop mode", 44'h4, {36'h0, d});
    u_host.rd(16'h0000, d);
    chk("unmapped", 44'h0, {36'h0, d});
    u_host.wr(fdc_pkg::BYPASS_OFS, 8'h00);
    u_host.wr(fdc_pkg::STEP_MASK_OFS, 8'h05);
    u_host.wr32(fdc_pkg::STEP_WORD_OFS, 32'h5);
    chk("bypass", 44'h0, {39'h0, byp});
    u_host.step(1'b0, 2'h1);
    chk_num(44'd35, 44'd30);
    u_host.step(1'b1, 2'h1);
    chk_num(44'd40, 44'd30);
    u_host.step(1'b0, 2'h2);
    chk_num(44'd35, 44'd30);
    u_host.step(1'b0, 2'h3);
    chk_num(44'd35, 44'd30);
    u_host.step(1'b1, 2'h3);
    chk_num(44'd35, 44'd30);
    u_host.wr32(fdc_pkg::STEP_WORD_OFS, 32'hffffffff);
    u_host.step(1'b0, 2'h1);
    chk_num(44'd4095, 44'd30);
    u_host.step(1'b1, 2'h2);
    chk_num(44'd10, 44'd30);
    u_host.wr32(16'h0416, 32'h2);
    u_host.wr32(16'h0415, 32'h0);
    u_host.wr32(16'h0415, 32'h28);
    repeat (2) @(posedge clk);
    chk("den1 before update", 44'h1, {12'h000, den[32 +: 32]});
    chk("num1 before update", 44'd10, num[44 +: 44]);
    u_host.wr(fdc_pkg::UPDATE_OFS, 8'h02);
    repeat (2) @(posedge clk);
    chk("den1 after update", 44'h2, {12'h000, den[32 +: 32]});
    chk("num1 after update", 44'd40, num[44 +: 44]);
    u_host.rd(16'h0417, d);
    chk("num1 low byte", 44'h28, {36'h0, d});
    u_host.wr32(16'h041e, 32'h3);
    u_host.wr32(16'h0422, 32'h7);
    u_host.wr(fdc_pkg::UPDATE_OFS, 8'h20);
    repeat (2) @(posedge clk);
    chk("den3", 44'h3, {12'h000, den[96 +: 32]});
    chk("den4", 44'h7, {12'h000, den[128 +: 32]});
    chk("den1", 44'h2, {12'h000, den[32 +: 32]});
    chk("den0", 44'h1, {12'h000, den[0 +: 32]});
    chk("num0", 44'd30, num[0 +: 44]);
    chk("num1", 44'd40, num[44 +: 44]);
    chk("num2", 44'd30, num[88 +: 44]);
    chk("num3 clamped", 44'd30, num[132 +: 44]);
    chk("num4 clamped", 44'd70, num[176 +: 44]);
    u_host.wr(fdc_pkg::LOOP_MODE_OFS, {5'h00, fdc_pkg::MODE_ZERO_DELAY});
    repeat (2) @(posedge clk);
    chk("zero delay", 44'h1, {43'h0, zero_delay_mode});
    chk("ext feedback", 44'h1, {43'h0, fbs});
    u_host.rd(fdc_pkg::LOOP_MODE_OFS, d);
    chk("loop mode", 44'h3, {36'h0, d});
    u_host.wr(fdc_pkg::STEP_CTRL_OFS, 8'h04);
    wait_pulse(n);
    chk("zdm delay ok", 44'h1, {43'h0, n >= HRC - 4 && n <= HRC + 4});
    repeat (10) @(posedge clk);
    chk("pending clear", 44'h0, {43'h0, pend});
    chk("bypass restored", 44'h1f, {39'h0, byp});
    chk_num(44'd30, 44'd30);
    u_host.wr(fdc_pkg::LOOP_MODE_OFS, {5'h00, fdc_pkg::MODE_NORMAL});
    u_host.wr(fdc_pkg::BYPASS_OFS, 8'h00);
    repeat (2) @(posedge clk);
    chk("bypass before reset", 44'h0, {39'h0, byp});
    u_host.rst_pin();
    repeat (2) @(posedge clk);
    chk("normal mode", 44'h0, {43'h0, zero_delay_mode});
    chk("normal reset at once", 44'h1f, {39'h0, byp});
    chk("no pending in normal", 44'h0, {43'h0, pend});
    repeat (20) @(posedge clk);
    conclude();
  end
endmodule
